// ===== cdmg_pkg.sv
// package: register map, field positions and reset values of the clock gating block
package cdmg_pkg;
    // ---------------------------------------------------------------
    // register word addresses (byte address = 4 * index)
    // ---------------------------------------------------------------
    localparam logic [3:0]  CDMG_IDX_CLOCK_DIVIDER_CONTROL  = 4'h0;   // clock_divider_control
    localparam logic [3:0]  CDMG_IDX_GATE1   = 4'h1;   // module_gate_ctrl_1
    localparam logic [3:0]  CDMG_IDX_GATE2   = 4'h2;   // module_gate_ctrl_2
    localparam logic [3:0]  CDMG_IDX_GATE3   = 4'h3;   // module_gate_ctrl_3
    localparam logic [3:0]  CDMG_IDX_GATE4   = 4'h4;   // module_gate_ctrl_4
    localparam logic [3:0]  CDMG_IDX_STATUS  = 4'h5;   // cpu enable and divider counter
    // ---------------------------------------------------------------
    // clock_divider_control fields
    // ---------------------------------------------------------------
    localparam int          CDMG_ROI_BIT     = 15;     // restore_on_interrupt
    localparam int          CDMG_RATIO_HI    = 14;     // ratio field top
    localparam int          CDMG_RATIO_LO    = 12;     // ratio field bottom
    localparam int          CDMG_CPU_SLOWDOWN_ENABLE_BIT   = 11;     // cpu_slowdown_enable
    // ---------------------------------------------------------------
    // implemented (writable) bits per register
    // ---------------------------------------------------------------
    localparam logic [15:0] CDMG_CLOCK_DIVIDER_CONTROL_MASK = 16'hF800;
    localparam logic [15:0] CDMG_GATE1_MASK  = 16'hFEFB; // bits 8 and 2 read zero
    localparam logic [15:0] CDMG_GATE2_MASK  = 16'h0F0F;
    localparam logic [15:0] CDMG_GATE3_MASK  = 16'h0482;
    localparam logic [15:0] CDMG_GATE4_MASK  = 16'h000C;
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [15:0] CDMG_CLOCK_DIVIDER_CONTROL_RST  = 16'h0000;
    localparam logic [15:0] CDMG_GATE_RST    = 16'h0000;
    localparam logic [31:0] CDMG_UNMAPPED    = 32'h00000000;
    // timing: gate change lands one instruction cycle after the write
    localparam int          CDMG_GATE_DELAY  = 1;
endpackage

// ===== cdmg_top.sv
// cpu doze divider and per-peripheral clock enable generator with avalon slave
// Summary of operation
// - slow cpu clock only while slowdown enabled
// - three-bit ratio field, 1:1 to 1:128
// - restore_on_interrupt clears slowdown on interrupt
// - without restore, interrupts leave slowdown alone
// - peripherals keep full-rate enable during slowdown
// - gate bit stops that peripheral's clock
// - disabled peripheral ignores writes, reads undefined
// - enable needs clear bit and peripheral present
// - gate bits reset to zero (enabled)
// - gate change takes effect one cycle later
// - gate1 bits 15..11 are timers five..one
// - gate1 bits 10,9 encoder, motor pwm; 8 zero
// - gate1 bits 7..3 serial, 1 can, 0 converter
// - gate2 capture 11..8, compare 3..0
// - gate3 comparator 10, checksum 7, i2c2 1
// - gate4 reference clock 3, charge timer 2
`timescale 1ns/1ns
module cdmg_top #(
    parameter logic [15:0] PRESENT1 = 16'hFEFB,  // peripherals fitted in this variant
    parameter logic [15:0] PRESENT2 = 16'h0F0F,
    parameter logic [15:0] PRESENT3 = 16'h0482,
    parameter logic [15:0] PRESENT4 = 16'h000C
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // interrupt event from the controller, same clock
    input  wire logic        irq_event,
    // cpu clock enable, one pulse per divided cpu cycle
    output logic             cpu_clk_en,
    // peripheral clock enables, high = clocked
    output logic      [15:0] periph_en1,
    output logic      [15:0] periph_en2,
    output logic      [15:0] periph_en3,
    output logic      [15:0] periph_en4
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // both helpers are used by several registers, so they live here once.
    // merge16 keeps unimplemented bits at zero by masking after the lane merge,
    // so a register never holds a bit that software could not read back.
    // live_en folds the variant presence mask in, so a missing peripheral
    // stays unclocked whatever software writes into its gate bit.
    // merge a write into a 16-bit register honouring byte lanes and mask
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be,
                                            input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (be[0]) begin
            v[7:0] = wd[7:0];
        end
        if (be[1]) begin
            v[15:8] = wd[15:8];
        end
        return v & mask;
    endfunction

    // live enable: bit clear and peripheral present
    function automatic logic [15:0] live_en(input logic [15:0] gate,
                                            input logic [15:0] present,
                                            input logic [15:0] mask);
        return ~gate & present & mask;
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [15:0] clock_divider_control_q;          // clock_divider_control
    logic [15:0] gate1_q;           // module_gate_ctrl_1
    logic [15:0] gate2_q;           // module_gate_ctrl_2
    logic [15:0] gate3_q;           // module_gate_ctrl_3
    logic [15:0] gate4_q;           // module_gate_ctrl_4
    logic        wait_q;            // waitrequest, low for one cycle per access
    logic [6:0]  div_cnt_q;         // doze divider counter
    logic        irq_restore;       // interrupt clears slowdown this cycle
    logic        wr_acc;            // write accepted this cycle
    logic [2:0]  ratio;             // current ratio field
    logic [6:0]  div_top;           // terminal count of the divider

    // local copies of the ratio field bounds, declared before any use
    localparam int CDMG_RATIO_HI_L = cdmg_pkg::CDMG_RATIO_HI;
    localparam int CDMG_RATIO_LO_L = cdmg_pkg::CDMG_RATIO_LO;

    // a write only takes effect on the edge where waitrequest is low
    assign wr_acc      = avs_write & ~wait_q;
    // ratio field taken straight from the divider control register
    assign ratio       = clock_divider_control_q[CDMG_RATIO_HI_L:CDMG_RATIO_LO_L];
    // terminal count 2^n - 1; the widest ratio still fits in seven bits
    assign div_top     = 7'((8'h01 << ratio) - 8'h01);
    // restore request uses the register value, not a write in flight
    assign irq_restore = irq_event & clock_divider_control_q[cdmg_pkg::CDMG_ROI_BIT];

    // ---------------------------------------------------------------
    // avalon handshake: one wait cycle, answer on the second edge
    // ---------------------------------------------------------------
    // the slave always answers after exactly one wait cycle, so a master
    // never sees a variable latency; waitrequest idles high so that a
    // request raised on any edge is taken before anything is changed.
    // after the answer edge the flag goes high again, which lets a new
    // request start at once without a stale answer being reused.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if ((avs_read | avs_write) & wait_q) begin
            wait_q <= 1'b0;                       // release for one edge
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign avs_waitrequest = wait_q;

    // ---------------------------------------------------------------
    // clock divider control; interrupt restore wins over a write
    // ---------------------------------------------------------------
    // the write is merged first and the interrupt applied afterwards, so
    // an interrupt landing on the same edge as a write that sets doze
    // still leaves the cpu at full speed when restore is enabled.
    // without restore the interrupt has no path into this register.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_divider_control_q <= cdmg_pkg::CDMG_CLOCK_DIVIDER_CONTROL_RST;
        end else begin
            logic [15:0] v;
            v = clock_divider_control_q;
            if (wr_acc && avs_address == cdmg_pkg::CDMG_IDX_CLOCK_DIVIDER_CONTROL) begin
                v = merge16(clock_divider_control_q, avs_writedata, avs_byteenable,
                            cdmg_pkg::CDMG_CLOCK_DIVIDER_CONTROL_MASK);
            end
            if (irq_event && v[cdmg_pkg::CDMG_ROI_BIT]) begin
                v[cdmg_pkg::CDMG_CPU_SLOWDOWN_ENABLE_BIT] = 1'b0;
            end
            clock_divider_control_q <= v;
        end
    end

    // ---------------------------------------------------------------
    // module gate registers; unimplemented bits held at zero
    // ---------------------------------------------------------------
    // one process for all four banks; each bank only reacts to its own
    // index, so a write never disturbs the gates of another bank.
    // bits of absent peripherals are still stored, as software wrote them.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate1_q <= cdmg_pkg::CDMG_GATE_RST;
            gate2_q <= cdmg_pkg::CDMG_GATE_RST;
            gate3_q <= cdmg_pkg::CDMG_GATE_RST;
            gate4_q <= cdmg_pkg::CDMG_GATE_RST;
        end else if (wr_acc) begin
            case (avs_address)
                cdmg_pkg::CDMG_IDX_GATE1: begin
                    gate1_q <= merge16(gate1_q, avs_writedata, avs_byteenable,
                                       cdmg_pkg::CDMG_GATE1_MASK);
                end
                cdmg_pkg::CDMG_IDX_GATE2: begin
                    gate2_q <= merge16(gate2_q, avs_writedata, avs_byteenable,
                                       cdmg_pkg::CDMG_GATE2_MASK);
                end
                cdmg_pkg::CDMG_IDX_GATE3: begin
                    gate3_q <= merge16(gate3_q, avs_writedata, avs_byteenable,
                                       cdmg_pkg::CDMG_GATE3_MASK);
                end
                cdmg_pkg::CDMG_IDX_GATE4: begin
                    gate4_q <= merge16(gate4_q, avs_writedata, avs_byteenable,
                                       cdmg_pkg::CDMG_GATE4_MASK);
                end
                default: begin
                    // other addresses leave the gates alone
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // peripheral enables, registered: land one cycle after the register
    // ---------------------------------------------------------------
    // the extra flop gives the one-cycle delay between a gate change and
    // the peripheral stopping or starting, and keeps the outputs glitch
    // free. during reset every enable is low; the first edge after release
    // switches on every fitted peripheral.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            periph_en1 <= 16'h0000;
            periph_en2 <= 16'h0000;
            periph_en3 <= 16'h0000;
            periph_en4 <= 16'h0000;
        end else begin
            // a low enable freezes the peripheral and its registers
            periph_en1 <= live_en(gate1_q, PRESENT1, cdmg_pkg::CDMG_GATE1_MASK);
            periph_en2 <= live_en(gate2_q, PRESENT2, cdmg_pkg::CDMG_GATE2_MASK);
            periph_en3 <= live_en(gate3_q, PRESENT3, cdmg_pkg::CDMG_GATE3_MASK);
            periph_en4 <= live_en(gate4_q, PRESENT4, cdmg_pkg::CDMG_GATE4_MASK);
        end
    end

    // ---------------------------------------------------------------
    // doze divider: peripherals untouched, cpu enable every 2^n cycles
    // ---------------------------------------------------------------
    // the system clock itself never changes; only this enable is thinned
    // out, so peripherals and registers stay in one clock domain.
    // a ratio change mid-count is safe: the >= compare ends an over-long
    // count at once instead of wrapping through all 128 states.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q  <= 7'h00;
            cpu_clk_en <= 1'b0;
        end else if (!clock_divider_control_q[cdmg_pkg::CDMG_CPU_SLOWDOWN_ENABLE_BIT] || irq_restore) begin
            div_cnt_q  <= 7'h00;
            cpu_clk_en <= 1'b1;
        end else if (div_cnt_q >= div_top) begin
            div_cnt_q  <= 7'h00;
            cpu_clk_en <= 1'b1;
        end else begin
            div_cnt_q  <= div_cnt_q + 7'h01;
            cpu_clk_en <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // read data, valid while waitrequest is low
    // ---------------------------------------------------------------
    // loaded on the take edge so it stands during the answer cycle; it
    // then holds until the next read. unmapped indices read as zero.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read & wait_q) begin
            case (avs_address)
                cdmg_pkg::CDMG_IDX_CLOCK_DIVIDER_CONTROL: avs_readdata <= {16'h0000, clock_divider_control_q};
                cdmg_pkg::CDMG_IDX_GATE1:  avs_readdata <= {16'h0000, gate1_q};
                cdmg_pkg::CDMG_IDX_GATE2:  avs_readdata <= {16'h0000, gate2_q};
                cdmg_pkg::CDMG_IDX_GATE3:  avs_readdata <= {16'h0000, gate3_q};
                cdmg_pkg::CDMG_IDX_GATE4:  avs_readdata <= {16'h0000, gate4_q};
                cdmg_pkg::CDMG_IDX_STATUS: avs_readdata <= {24'h000000, cpu_clk_en,
                                                            div_cnt_q};
                default:                   avs_readdata <= cdmg_pkg::CDMG_UNMAPPED;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_gate1_write;
        wr_acc && avs_address == cdmg_pkg::CDMG_IDX_GATE1 && avs_byteenable[1];
    endsequence

    a_full_speed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clock_divider_control_q[cdmg_pkg::CDMG_CPU_SLOWDOWN_ENABLE_BIT] |=> cpu_clk_en)
        else $error("cpu enable missing at full speed");
    a_ratio_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (clock_divider_control_q[cdmg_pkg::CDMG_CPU_SLOWDOWN_ENABLE_BIT] && ratio == 3'h1 && cpu_clk_en
         && !irq_event && $stable(clock_divider_control_q)) |=> !cpu_clk_en)
        else $error("ratio 2 gave back-to-back cpu enables");
    a_count_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        div_cnt_q <= div_top || $changed(ratio))
        else $error("divider counter past terminal count");
    a_irq_restore: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_restore |=> !clock_divider_control_q[cdmg_pkg::CDMG_CPU_SLOWDOWN_ENABLE_BIT])
        else $error("interrupt did not restore full speed");
    a_irq_ignored: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (irq_event && !clock_divider_control_q[cdmg_pkg::CDMG_ROI_BIT] && !wr_acc)
        |=> $stable(clock_divider_control_q))
        else $error("interrupt changed doze without restore");
    a_gate_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_gate1_write ##1 1'b1 |=> periph_en1 ==
        (~$past(gate1_q) & PRESENT1 & cdmg_pkg::CDMG_GATE1_MASK))
        else $error("gate change not one cycle after write");
    a_absent_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (periph_en1 & ~PRESENT1) == 16'h0000)
        else $error("absent peripheral enabled");
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        gate1_q[8] == 1'b0 && gate1_q[2] == 1'b0 && gate2_q[15:12] == 4'h0
        && gate3_q[0] == 1'b0 && gate4_q[15:4] == 12'h000)
        else $error("reserved gate bit set");
    a_disable_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        gate4_q[3] |=> !periph_en4[3])
        else $error("disabled reference clock still enabled");

    // ---------------------------------------------------------------
    // further checks: bus pacing, restore rate and the other gate banks
    // ---------------------------------------------------------------
    // a request seen while the slave is idle
    sequence s_bus_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    // the single answer cycle followed by the return to idle
    sequence s_bus_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    // register access stays synchronous and fixed in latency
    a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_bus_take |=> s_bus_answer)
        else $error("register access not answered in one cycle");
    // restore gives a cpu enable on the very next cycle
    a_restore_rate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_restore |=> cpu_clk_en)
        else $error("cpu enable missing after interrupt restore");
    // ratio zero in doze still runs the cpu every cycle
    a_ratio_unity: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clock_divider_control_q[cdmg_pkg::CDMG_CPU_SLOWDOWN_ENABLE_BIT] && ratio == 3'h0 |=> cpu_clk_en)
        else $error("ratio one to one dropped a cpu enable");
    // divider rests at zero outside doze
    a_idle_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !clock_divider_control_q[cdmg_pkg::CDMG_CPU_SLOWDOWN_ENABLE_BIT] |=> div_cnt_q == 7'h00)
        else $error("divider running outside doze");
    // any set capture or compare gate stops that unit
    a_gate2_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        gate2_q != 16'h0000 |=> (periph_en2 & $past(gate2_q)) == 16'h0000)
        else $error("disabled capture or compare unit still enabled");
    // any set gate of the third bank stops that unit
    a_gate3_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        gate3_q != 16'h0000 |=> (periph_en3 & $past(gate3_q)) == 16'h0000)
        else $error("disabled comparator, checksum or i2c still enabled");
    // clear gates enable every fitted peripheral of the first bank
    a_all_fitted_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        gate1_q == 16'h0000 |=>
        periph_en1 == (PRESENT1 & cdmg_pkg::CDMG_GATE1_MASK))
        else $error("fitted peripheral not enabled with gate clear");
endmodule

// ===== cdmg_periph_model.sv
// far-side model: the gated peripherals, recording which ones received clock
`timescale 1ns/1ns
module cdmg_periph_model (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        clr,
    input  wire logic [15:0] periph_en1,
    input  wire logic [15:0] periph_en2,
    input  wire logic [15:0] periph_en3,
    input  wire logic [15:0] periph_en4,
    output logic      [63:0] ran_q
);
    // ---------------------------------------------------------------
    // activity record
    // ---------------------------------------------------------------
    // a peripheral only advances on edges where its enable is high
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ran_q <= 64'h0;
        end else if (clr) begin
            ran_q <= 64'h0;
        end else begin
            ran_q <= ran_q | {periph_en4, periph_en3, periph_en2, periph_en1};
        end
    end
endmodule

// ===== cpu_doze_and_module_clock_gating_tb.sv
// self-checking bench for the doze divider and module clock gates
`timescale 1ns/1ns
module cpu_doze_and_module_clock_gating_tb;
    localparam logic [15:0] P1 = 16'hF8FB;  // variant without encoder and motor pwm
    localparam logic [15:0] P2 = 16'h0F0F;
    localparam logic [15:0] P3 = 16'h0402;  // variant without checksum unit
    localparam logic [15:0] P4 = 16'h000C;
    logic        sys_clk       = 1'b0;
    logic        rst_n         = 1'b0;
    logic [3:0]  avs_address   = 4'h0;
    logic        avs_read      = 1'b0;
    logic        avs_write     = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq_event     = 1'b0;
    logic        cpu_clk_en;
    logic [15:0] en1, en2, en3, en4;
    logic        clr           = 1'b0;
    logic [63:0] ran_q;
    logic [31:0] seed          = 32'hBE95;
    logic [15:0] g [1:4];                   // implemented bits of the last value written to each gate register
    logic [31:0] q;
    int          err_total     = 0;
    int          n_checks      = 0;
    int          cnt;

    // clock
    always #4 sys_clk = ~sys_clk;

    cdmg_top #(.PRESENT1(P1), .PRESENT2(P2), .PRESENT3(P3), .PRESENT4(P4)) dut_u (
        .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq_event(irq_event), .cpu_clk_en(cpu_clk_en), .periph_en1(en1),
        .periph_en2(en2), .periph_en3(en3), .periph_en4(en4));
    cdmg_periph_model peri_u (.sys_clk(sys_clk), .rst_n(rst_n), .clr(clr),
        .periph_en1(en1), .periph_en2(en2), .periph_en3(en3), .periph_en4(en4), .ran_q(ran_q));

    // xorshift source for random write data
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // implemented bits and fitted peripherals per gate register
    function automatic logic [15:0] msk(input int r);
        return r == 1 ? cdmg_pkg::CDMG_GATE1_MASK : r == 2 ? cdmg_pkg::CDMG_GATE2_MASK :
               r == 3 ? cdmg_pkg::CDMG_GATE3_MASK : cdmg_pkg::CDMG_GATE4_MASK;
    endfunction
    function automatic logic [15:0] pres(input int r);
        return r == 1 ? P1 : r == 2 ? P2 : r == 3 ? P3 : P4;
    endfunction

    // compare and count
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] v);
        n_checks++;
        if (v !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, v);
        end
    endtask
    // one avalon transfer, entered just after an edge; leaves one idle edge behind it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rq);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 50) chk("bus answer", 64'h0, 64'h1);
        rq = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask
    // count cpu enable pulses over a window
    task automatic count_en(input int cyc);
        cnt = 0;
        repeat (cyc) begin
            @(posedge sys_clk);
            if (cpu_clk_en === 1'b1) cnt++;
        end
    endtask
    // pulse the interrupt event for one cycle
    task automatic irq();
        irq_event <= 1'b1;
        @(posedge sys_clk);
        irq_event <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #(8 * 20000);
        err_total++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, 4'(i), 32'h0, q);
            chk("reset value", 64'h0, {32'h0, q});
        end
        bus(1'b0, 4'hF, 32'h0, q);
        chk("unmapped read", 64'h0, {32'h0, q});
        chk("enables after reset", {P4, P3, P2, P1}, {en4, en3, en2, en1});
        // random gate patterns, including bits of absent peripherals
        for (int k = 0; k < 6; k++) begin
            for (int r = 1; r < 5; r++) begin
                seed = xs(seed);
                g[r] = seed[15:0] & msk(r);
                bus(1'b1, 4'(r), seed, q);
                repeat (2) @(posedge sys_clk);
                chk("gate enable", {48'h0, pres(r) & ~g[r]},
                    {48'h0, r == 1 ? en1 : r == 2 ? en2 : r == 3 ? en3 : en4});
                bus(1'b0, 4'(r), 32'h0, q);
                chk("gate readback", {48'h0, g[r]}, {32'h0, q});
            end
        end
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk("clocked peripherals", {P4 & ~g[4], P3 & ~g[3], P2 & ~g[2], P1 & ~g[1]}, ran_q);
        // every doze ratio
        for (int n = 0; n < 8; n++) begin
            bus(1'b1, 4'h0, 32'h0800 | (n << 12), q);
            repeat (4) @(posedge sys_clk);
            count_en(256);
            chk("cpu pulses", 64'(256 >> n), 64'(cnt));
            chk("enables in doze", {P4 & ~g[4], P1 & ~g[1]}, {en4, en1});
        end
        bus(1'b1, 4'h0, 32'h3000, q);
        count_en(256);
        chk("cpu pulses no doze", 64'd256, 64'(cnt));
        // interrupt with restore set ends the slowdown
        bus(1'b1, 4'h0, 32'hB800, q);
        irq();
        bus(1'b0, 4'h0, 32'h0, q);
        chk("restore clears doze", 64'hB000, {32'h0, q});
        count_en(64);
        chk("full speed after irq", 64'd64, 64'(cnt));
        // interrupt without restore leaves the slowdown alone
        bus(1'b1, 4'h0, 32'h3800, q);
        irq();
        bus(1'b0, 4'h0, 32'h0, q);
        chk("doze kept", 64'h3800, {32'h0, q});
        count_en(256);
        chk("slow after irq", 64'd32, 64'(cnt));
        give_verdict();
    end
endmodule
